// ### dv/lsti_host_model.sv
// Host controller model: APB master tasks and pulled up interrupt wire
`timescale 1ns/1ns
module lsti_host_model
	import lsti_pkg::*;
(
	// Clock
	input  wire logic              i_sys_clk,
	// APB master side
	output logic                   o_psel,
	output logic                   o_penable,
	output logic                   o_pwrite,
	output logic      [ADDR_W-1:0] o_paddr,
	output logic      [DATA_W-1:0] o_pwdata,
	input  wire logic              i_pready,
	input  wire logic [DATA_W-1:0] i_prdata,
	input  wire logic              i_pslverr,
	// Interrupt wire with board pull-up
	input  wire logic              i_int_n_o,
	input  wire logic              i_int_n_oe,
	output logic                   o_int_level
);
	// Released line floats to the pull-up level
	assign o_int_level = i_int_n_oe ? i_int_n_o : 1'b1;

	// Idle bus at time zero
	initial begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = '0;
		o_pwdata  = '0;
	end

	// One transfer, then an idle cycle keeps the host rate modest
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
		output logic e);
		@(posedge i_sys_clk);
		o_psel   <= 1'b1;
		o_pwrite <= wr;
		o_paddr  <= a;
		o_pwdata <= d;
		@(posedge i_sys_clk);
		o_penable <= 1'b1;
		do @(posedge i_sys_clk); while (i_pready !== 1'b1);
		q = i_prdata;
		e = i_pslverr;
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
		// Released data no longer shows the written word
		o_pwdata  <= ~d;
	endtask
endmodule

// ### dv/lsti_top_props.sv
// Port level checks for the light sensor threshold interrupt core
`timescale 1ns/1ns
module lsti_top_props
	import lsti_pkg::*;
#(
	parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
) (
	// Clock and reset
	input wire logic              i_sys_clk,
	input wire logic              i_rst,
	// APB slave side
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [DATA_W-1:0] i_pwdata,
	input wire logic              o_pready,
	input wire logic [DATA_W-1:0] o_prdata,
	input wire logic              o_pslverr,
	// Interrupt outputs
	input wire logic              o_int_n_o,
	input wire logic              o_int_n_oe,
	input wire logic              o_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	// Access phase of a transfer
	wire acc = i_psel && i_penable;
	// Writes that may legally drop the pin or the irq
	wire pin_wr = acc && i_pwrite &&
		(i_paddr == OFS_STATUS || i_paddr == OFS_CTRL);
	wire irq_wr = acc && i_pwrite &&
		(i_paddr == OFS_STATUS || i_paddr == OFS_MASK);

	a_pready_high: assert property (o_pready)
		else $error("pready low");
	a_err_in_access: assert property (o_pslverr |-> acc)
		else $error("pslverr outside access");
	a_err_unmapped: assert property (acc && i_paddr > OFS_STATE |-> o_pslverr)
		else $error("no error on unmapped address");
	a_err_rdata: assert property (acc && o_pslverr |-> o_prdata == '0)
		else $error("error read not zero");
	a_pin_drive_low: assert property (o_int_n_oe |-> !o_int_n_o)
		else $error("pin driven high");
	// Pin only drops on a clear, an enable change or a reset
	a_pin_hold_set: assert property ($fell(o_int_n_oe) |->
		$past(pin_wr, 1) || $past(pin_wr, 2) || $past(i_rst, 2))
		else $error("pin released without clear");
	// Sticky status keeps irq high until software acts
	a_irq_hold_set: assert property ($fell(o_irq) |->
		$past(irq_wr, 1) || $past(irq_wr, 2) || $past(i_rst, 2))
		else $error("irq dropped without clear");
	a_rst_quiet: assert property ($fell(i_rst) |->
		!o_irq && !o_int_n_oe && o_prdata == '0)
		else $error("outputs active after reset");

	// Main scenarios
	c_pin_rise: cover property ($rose(o_int_n_oe));
	c_irq_rise: cover property ($rose(o_irq));
	c_slv_err: cover property (acc && o_pslverr);
endmodule

// ### dv/test_light_sensor_threshold_interrupt.sv
// Self-checking bench of the light sensor threshold interrupt core
`timescale 1ns/1ns
module test_light_sensor_threshold_interrupt
	import lsti_pkg::*;
;
	// Short steps keep each interval to a few cycles
	localparam int unsigned STEPC = 4;
	logic              i_sys_clk, i_rst, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, q;
	logic              pready, pslverr, int_o, int_oe, irq, pin, e;
	logic [SAMPLE_W-1:0] fs_cnt, ir_cnt;
	int                bad_count, samples_checked, cyc;
	// Reset value rows: address beside expected read word
	logic [ADDR_W-1:0] row_a [9] = '{OFS_CTRL, OFS_INTEG, OFS_WAIT,
		OFS_THR_LO, OFS_THR_HI, OFS_PERSIST, OFS_STATUS, OFS_MASK,
		OFS_STATE};
	logic [DATA_W-1:0] row_x [9] = '{32'h0, 32'hff, 32'hff, 32'h0,
		32'hffff, 32'h0, 32'h0, 32'h0, 32'h4};

	lsti_top #(.P_STEP_CYCLES(STEPC)) dut_u (.i_sys_clk(i_sys_clk),
		.i_rst(i_rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_fs_step_counts(fs_cnt), .i_ir_step_counts(ir_cnt),
		.i_int_n_i(pin), .o_int_n_o(int_o), .o_int_n_oe(int_oe),
		.o_irq(irq));
	lsti_host_model host_u (.i_sys_clk(i_sys_clk), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata), .i_pready(pready), .i_prdata(prdata),
		.i_pslverr(pslverr), .i_int_n_o(int_o), .i_int_n_oe(int_oe),
		.o_int_level(pin));

	// Clock of 10 ns
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	// Compare and count
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
		samples_checked++;
		if (s !== x) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		host_u.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		host_u.xfer(1'b0, a, '0, q, e);
		chk(q, x);
	endtask
	// Bounded wait for the level interrupt
	task automatic wait_irq();
		int n;
		n = 0;
		// Let one edge pass so a level dropped by the last write is seen
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (irq !== 1'b1 && n < 300);
		chk({31'h0, irq}, 32'h1);
	endtask
	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, generous beside the few hundred cycles expected
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		i_rst = 1'b1;
		fs_cnt = 11'h7ff;
		ir_cnt = 11'h032;
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		// Reset values, pin released and pulled up
		for (int i = 0; i < 9; i++) rd(row_a[i], row_x[i]);
		host_u.xfer(1'b0, 12'h02c, 32'h0, q, e);
		chk({q[30:0], e}, 32'h1);
		// Two steps, full spectrum clamped per step
		wr(OFS_INTEG, 32'hfe);
		wr(OFS_MASK, 32'h2);
		wr(OFS_CTRL, 32'h3);
		wait_irq();
		rd(OFS_FS_DATA, 32'h800);
		rd(OFS_IR_DATA, 32'h64);
		// Stop measuring first so no fresh result re-sets the status
		wr(OFS_CTRL, 32'h1);
		wr(OFS_STATUS, 32'h2);
		repeat (2) @(posedge i_sys_clk);
		chk({31'h0, irq}, 32'h0);
		// Three outside results before the pin asserts
		fs_cnt <= 11'h064;
		wr(OFS_THR_HI, 32'h96);
		wr(OFS_PERSIST, 32'h3);
		wr(OFS_STATUS, 32'h3);
		wr(OFS_CTRL, 32'hb);
		for (int k = 1; k <= 3; k++) begin
			wait_irq();
			@(posedge i_sys_clk);
			chk({31'h0, int_oe}, (k == 3) ? 32'h1 : 32'h0);
			chk({31'h0, pin}, (k == 3) ? 32'h0 : 32'h1);
			if (k < 3) wr(OFS_STATUS, 32'h2);
		end
		// Level stays down across later results
		repeat (40) @(posedge i_sys_clk);
		chk({31'h0, pin}, 32'h0);
		// Halt results so none lands in the clearing cycle
		wr(OFS_CTRL, 32'h9);
		wr(OFS_STATUS, 32'h1);
		repeat (2) @(posedge i_sys_clk);
		chk({31'h0, pin}, 32'h1);
		// Events with interrupts disabled leave the pin released
		wr(OFS_CTRL, 32'h3);
		repeat (60) @(posedge i_sys_clk);
		chk({31'h0, int_oe}, 32'h0);
		// Below the lower bound, then sleep after the event
		wr(OFS_CTRL, 32'h1);
		wr(OFS_THR_HI, 32'hffff);
		wr(OFS_THR_LO, 32'h12c);
		wr(OFS_PERSIST, 32'h0);
		wr(OFS_STATUS, 32'h3);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CTRL, 32'h13);
		wait_irq();
		repeat (3) @(posedge i_sys_clk);
		rd(OFS_STATE, 32'h4);
		stop_test();
	end
endmodule

bind lsti_top lsti_top_props #(.P_STEP_CYCLES(P_STEP_CYCLES)) props_u (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .o_int_n_o(o_int_n_o),
	.o_int_n_oe(o_int_n_oe), .o_irq(o_irq));

// ### hw/lsti_converter.sv
// Two integrating channel accumulators running side by side
`timescale 1ns/1ns
module lsti_converter
	import lsti_pkg::*;
(
	// Clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	// Per step counts from the two front ends
	input  wire logic [SAMPLE_W-1:0] i_fs_step_counts,
	input  wire logic [SAMPLE_W-1:0] i_ir_step_counts,
	// Sequencer link
	lsti_seq_if.cnv                  seq
);

	typedef struct packed {
		logic                mode;   // Current interval integrates
		logic [RESULT_W-1:0] fs_acc; // Full spectrum running sum
		logic [RESULT_W-1:0] ir_acc; // Infrared running sum
		logic [RESULT_W-1:0] fs_res; // Full spectrum result
		logic [RESULT_W-1:0] ir_res; // Infrared result
		logic                valid;  // Result pulse
	} lsti_cnv_state_t;

	lsti_cnv_state_t q;
	lsti_cnv_state_t d;

	assign seq.fs_result = q.fs_res;
	assign seq.ir_result = q.ir_res;
	assign seq.valid     = q.valid;

	// Both channels accumulate on the same step; sums saturate, never wrap
	always_comb begin
		d       = q;
		d.valid = 1'b0;
		if (seq.abort) begin
			d.mode = 1'b0;
		end else if (seq.start) begin
			d.mode = seq.integrate;
			// A new integration starts from zero
			if (seq.integrate) begin
				d.fs_acc = '0;
				d.ir_acc = '0;
			end
		end else if (seq.step && q.mode) begin
			d.fs_acc = lsti_sat_add(q.fs_acc, i_fs_step_counts);
			d.ir_acc = lsti_sat_add(q.ir_acc, i_ir_step_counts);
			// Last step publishes both sums together
			if (seq.done) begin
				d.fs_res = d.fs_acc;
				d.ir_res = d.ir_acc;
				d.valid  = 1'b1;
				d.mode   = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// ### hw/lsti_step_timer.sv
// Step timer shared by the integration and the wait intervals
`timescale 1ns/1ns
module lsti_step_timer
	import lsti_pkg::*;
#(
	parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
) (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// Sequencer link
	lsti_seq_if.tmr   seq
);

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(P_STEP_CYCLES - 1);

	typedef struct packed {
		logic               active; // Interval running
		logic [DIV_W-1:0]   div;    // Cycles within the step
		logic [STEPS_W-1:0] left;   // Steps still to run
	} lsti_tmr_state_t;

	lsti_tmr_state_t q;
	lsti_tmr_state_t d;
	logic            step_c;

	// Step enable pulse and end of interval
	assign step_c   = q.active && (q.div == DIV_LAST);
	assign seq.step = step_c;
	assign seq.done = step_c && (q.left == STEPS_W'(1));

	// Next state: a start restarts the divider so every step is full length
	always_comb begin
		d = q;
		if (seq.abort) begin
			d.active = 1'b0;
		end else if (seq.start) begin
			d.active = 1'b1;
			d.div    = '0;
			d.left   = seq.steps;
		end else if (step_c) begin
			d.div  = '0;
			d.left = q.left - STEPS_W'(1);
			// Last step ends the interval
			if (q.left == STEPS_W'(1)) begin
				d.active = 1'b0;
			end
		end else if (q.active) begin
			d.div = q.div + DIV_W'(1);
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// ### hw/lsti_top.sv
// Light sensor threshold interrupt core with APB register slave
//
// How it works
// - Both channels integrate together, 16-bit results
// - Finished cycle copies both results to data registers
// - Interrupt appears as a level on its pin
// - Pin asserts only when enabled and event qualified
// - Asserted pin holds until host clears it
// - Event when result above upper or below lower
// - Persistence count of consecutive outside results
// - Pin is open drain, low when asserted
// - Host port answers every transfer without wait states
// - Programmable wait between measurement cycles
// - Optional sleep after interrupt stops measuring
// - Wait is 1 to 256 steps of 2.73 ms
// - Integration 1 to 256 steps, 1024 counts each
`timescale 1ns/1ns
module lsti_top
	import lsti_pkg::*;
#(
	parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
) (
	// Clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	// APB slave
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [ADDR_W-1:0]   i_paddr,
	input  wire logic [DATA_W-1:0]   i_pwdata,
	output logic                     o_pready,
	output logic      [DATA_W-1:0]   o_prdata,
	output logic                     o_pslverr,
	// Per step counts from the photodiode front ends
	input  wire logic [SAMPLE_W-1:0] i_fs_step_counts,
	input  wire logic [SAMPLE_W-1:0] i_ir_step_counts,
	// Open drain interrupt pin, active low
	input  wire logic                i_int_n_i,
	output logic                     o_int_n_o,
	output logic                     o_int_n_oe,
	// Maskable system interrupt
	output logic                     o_irq
);

	// All state of the control core; timer and converter keep their own
	typedef struct packed {
		lsti_state_t          fsm;      // Sequencer state
		logic [CTRL_W-1:0]    ctrl;     // Control bits
		logic [SETTING_W-1:0] integ;    // Integration length setting
		logic [SETTING_W-1:0] wait_len; // Wait length setting
		logic [RESULT_W-1:0]  thr_lo;   // Lower threshold
		logic [RESULT_W-1:0]  thr_hi;   // Upper threshold
		logic [PERS_W-1:0]    persist;  // Needed consecutive hits
		logic [PERS_W-1:0]    hits;     // Consecutive outside count
		logic [RESULT_W-1:0]  fs_data;  // Full spectrum data
		logic [RESULT_W-1:0]  ir_data;  // Infrared data
		logic [STATUS_W-1:0]  status;   // Sticky events
		logic [STATUS_W-1:0]  mask;     // Event mask
		logic                 pin_act;  // Interrupt pin asserted
		logic                 irq;      // System interrupt level
		logic [DATA_W-1:0]    prdata;   // Read data
	} lsti_top_state_t;

	localparam lsti_top_state_t RST_STATE = '{
		fsm:      FSM_SLEEP,
		ctrl:     CTRL_RST,
		integ:    INTEG_RST,
		wait_len: WAIT_RST,
		thr_lo:   THR_LO_RST,
		thr_hi:   THR_HI_RST,
		persist:  PERS_RST,
		hits:     '0,
		fs_data:  '0,
		ir_data:  '0,
		status:   '0,
		mask:     MASK_RST,
		pin_act:  1'b0,
		irq:      1'b0,
		prdata:   '0
	};

	lsti_top_state_t q;
	lsti_top_state_t d;

	// Sequencer link shared with the timer and the converter
	lsti_seq_if seq ();

	// Bus decode
	logic                setup_c;  // APB setup phase
	logic                access_c; // APB access phase
	logic                mapped_c; // Address hits a register
	logic                wr_c;     // Write takes effect now
	logic [DATA_W-1:0]   rd_c;     // Read value of the address
	// Sequencer requests
	logic                start_c;
	logic                integ_c;
	logic [STEPS_W-1:0]  steps_c;
	logic                abort_c;
	// Event evaluation
	logic                outside_c;
	logic [PERS_W-1:0]   need_c;
	logic                thr_evt_c;
	logic [STATUS_W-1:0] clr_c;
	logic [STATUS_W-1:0] set_c;

	// Step timer for integration and wait intervals
	lsti_step_timer #(
		.P_STEP_CYCLES (P_STEP_CYCLES)
	) u_timer (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.seq       (seq.tmr)
	);

	// Dual channel converter
	lsti_converter u_conv (
		.i_sys_clk        (i_sys_clk),
		.i_rst            (i_rst),
		.i_fs_step_counts (i_fs_step_counts),
		.i_ir_step_counts (i_ir_step_counts),
		.seq              (seq.cnv)
	);

	assign seq.start     = start_c;
	assign seq.abort     = abort_c;
	assign seq.integrate = integ_c;
	assign seq.steps     = steps_c;

	// APB phases; the slave never inserts wait states
	assign setup_c  = i_psel && !i_penable;
	assign access_c = i_psel && i_penable;
	assign wr_c     = access_c && i_pwrite && mapped_c;

	// Register read mux; unmapped addresses read zero and flag an error
	always_comb begin
		rd_c     = '0;
		mapped_c = 1'b1;
		unique case (i_paddr)
			OFS_CTRL:    rd_c[CTRL_W-1:0]    = q.ctrl;
			OFS_INTEG:   rd_c[SETTING_W-1:0] = q.integ;
			OFS_WAIT:    rd_c[SETTING_W-1:0] = q.wait_len;
			OFS_THR_LO:  rd_c[RESULT_W-1:0]  = q.thr_lo;
			OFS_THR_HI:  rd_c[RESULT_W-1:0]  = q.thr_hi;
			OFS_PERSIST: rd_c[PERS_W-1:0]    = q.persist;
			OFS_FS_DATA: rd_c[RESULT_W-1:0]  = q.fs_data;
			OFS_IR_DATA: rd_c[RESULT_W-1:0]  = q.ir_data;
			OFS_STATUS:  rd_c[STATUS_W-1:0]  = q.status;
			OFS_MASK:    rd_c[STATUS_W-1:0]  = q.mask;
			OFS_STATE: begin
				rd_c[1:0]           = q.fsm;
				rd_c[STATE_PIN_BIT] = i_int_n_i;
			end
			default: mapped_c = 1'b0;
		endcase
	end

	// Threshold test on the fresh full spectrum result
	assign outside_c = (seq.fs_result > q.thr_hi) ||
		(seq.fs_result < q.thr_lo);
	// A persistence of zero still needs one outside result
	assign need_c    = (q.persist == '0) ? PERS_W'(1) : q.persist;

	// Sequencer: measure, optionally wait, repeat, or fall asleep
	always_comb begin
		start_c   = 1'b0;
		integ_c   = 1'b0;
		steps_c   = lsti_steps(q.integ);
		abort_c   = 1'b0;
		thr_evt_c = 1'b0;
		d         = q;
		d.prdata  = q.prdata;

		// Register writes take effect at the access edge
		clr_c = '0;
		if (wr_c) begin
			unique case (i_paddr)
				OFS_CTRL:    d.ctrl     = i_pwdata[CTRL_W-1:0];
				OFS_INTEG:   d.integ    = i_pwdata[SETTING_W-1:0];
				OFS_WAIT:    d.wait_len = i_pwdata[SETTING_W-1:0];
				OFS_THR_LO:  d.thr_lo   = i_pwdata[RESULT_W-1:0];
				OFS_THR_HI:  d.thr_hi   = i_pwdata[RESULT_W-1:0];
				OFS_PERSIST: d.persist  = i_pwdata[PERS_W-1:0];
				OFS_STATUS:  clr_c      = i_pwdata[STATUS_W-1:0];
				OFS_MASK:    d.mask     = i_pwdata[STATUS_W-1:0];
				default: ;
			endcase
		end

		// Host clear of the threshold event restarts qualification
		if (clr_c[STAT_THR_BIT]) begin
			d.hits = '0;
		end

		// New results: publish, compare, qualify
		if (seq.valid) begin
			d.fs_data = seq.fs_result;
			d.ir_data = seq.ir_result;
			if (outside_c) begin
				// Saturate so a long excursion cannot wrap to zero
				if (q.hits != PERS_MAX) begin
					d.hits = q.hits + PERS_W'(1);
				end
				thr_evt_c = ((q.hits + PERS_W'(1)) >= need_c) ||
					(q.hits == PERS_MAX);
			end else begin
				d.hits = '0;
			end
		end

		// Sticky status: an event in the clearing cycle survives
		set_c                = '0;
		set_c[STAT_THR_BIT]  = thr_evt_c;
		set_c[STAT_DATA_BIT] = seq.valid;
		d.status = (q.status & ~clr_c) | set_c;

		// Sequencer transitions
		unique case (q.fsm)
			FSM_SLEEP: begin
				// Leave sleep once powered and either the event is cleared or the sleep bit is off
				if (d.ctrl[CTRL_PON_BIT] && !d.status[STAT_THR_BIT]) begin
					d.fsm = FSM_IDLE;
				end else if (d.ctrl[CTRL_PON_BIT] &&
					!d.ctrl[CTRL_SLEEP_BIT]) begin
					d.fsm = FSM_IDLE;
				end
			end
			FSM_IDLE: begin
				if (d.ctrl[CTRL_PON_BIT] && d.ctrl[CTRL_MEAS_BIT]) begin
					start_c = 1'b1;
					integ_c = 1'b1;
					steps_c = lsti_steps(d.integ);
					d.fsm   = FSM_INTEG;
				end
			end
			FSM_INTEG: begin
				if (seq.valid) begin
					if (thr_evt_c && d.ctrl[CTRL_SLEEP_BIT]) begin
						d.fsm = FSM_SLEEP;
					end else if (d.ctrl[CTRL_WAIT_BIT]) begin
						start_c = 1'b1;
						steps_c = lsti_steps(d.wait_len);
						d.fsm   = FSM_WAIT;
					end else begin
						start_c = 1'b1;
						integ_c = 1'b1;
						steps_c = lsti_steps(d.integ);
					end
				end
			end
			FSM_WAIT: begin
				if (seq.done) begin
					start_c = 1'b1;
					integ_c = 1'b1;
					steps_c = lsti_steps(d.integ);
					d.fsm   = FSM_INTEG;
				end
			end
		endcase

		// Power off or measurement disable stops any interval at once
		if (q.fsm != FSM_SLEEP && !d.ctrl[CTRL_PON_BIT]) begin
			abort_c = 1'b1;
			start_c = 1'b0;
			d.fsm   = FSM_SLEEP;
		end else if ((q.fsm == FSM_INTEG || q.fsm == FSM_WAIT) &&
			!d.ctrl[CTRL_MEAS_BIT] && d.fsm != FSM_SLEEP) begin
			abort_c = 1'b1;
			start_c = 1'b0;
			d.fsm   = FSM_IDLE;
		end

		// Pin follows the sticky event only while enabled
		d.pin_act = d.ctrl[CTRL_INT_BIT] &&
			d.status[STAT_THR_BIT];
		// System interrupt: any unmasked sticky event
		d.irq = |(d.status & d.mask);

		// Read data is caught in setup so it stands through access
		if (setup_c) begin
			d.prdata = rd_c;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// APB answers in the first access cycle; host rate needs no throttle
	assign o_pready  = 1'b1;
	assign o_pslverr = access_c && !mapped_c;
	assign o_prdata  = q.prdata;

	// Open drain: only ever pulls low, released otherwise
	assign o_int_n_o  = 1'b0;
	assign o_int_n_oe = q.pin_act;
	assign o_irq      = q.irq;

endmodule

// ### shared/lsti_pkg.sv
// Shared constants, types and helpers of the light sensor threshold block
package lsti_pkg;

	// System clock and measurement step timing
	localparam int unsigned SYS_CLK_PERIOD_NS = 10;
	localparam int unsigned STEP_TIME_US      = 2730;
	localparam int unsigned STEP_CYCLES       =
		(STEP_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int unsigned DIV_W             = 19;

	// Field widths
	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned SETTING_W = 8;
	localparam int unsigned STEPS_W   = 9;
	localparam int unsigned RESULT_W  = 16;
	localparam int unsigned SAMPLE_W  = 11;
	localparam int unsigned PERS_W    = 4;
	localparam int unsigned CTRL_W    = 5;
	localparam int unsigned STATUS_W  = 2;

	// Numeric limits
	localparam logic [STEPS_W-1:0]  STEP_SPAN  = 9'h100;
	localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 11'h400;
	localparam logic [RESULT_W-1:0] RESULT_MAX = 16'hffff;
	localparam logic [PERS_W-1:0]   PERS_MAX   = 4'hf;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_INTEG    = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_WAIT     = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_THR_LO   = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_THR_HI   = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_PERSIST  = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_FS_DATA  = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_IR_DATA  = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_MASK     = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_STATE    = 12'h028;

	// Control register bit positions
	localparam int unsigned CTRL_PON_BIT   = 0;
	localparam int unsigned CTRL_MEAS_BIT  = 1;
	localparam int unsigned CTRL_WAIT_BIT  = 2;
	localparam int unsigned CTRL_INT_BIT   = 3;
	localparam int unsigned CTRL_SLEEP_BIT = 4;

	// Status and mask bit positions
	localparam int unsigned STAT_THR_BIT  = 0;
	localparam int unsigned STAT_DATA_BIT = 1;

	// State readback bit position of the pin level
	localparam int unsigned STATE_PIN_BIT = 2;

	// Reset values
	localparam logic [CTRL_W-1:0]    CTRL_RST    = 5'h00;
	localparam logic [SETTING_W-1:0] INTEG_RST   = 8'hff;
	localparam logic [SETTING_W-1:0] WAIT_RST    = 8'hff;
	localparam logic [RESULT_W-1:0]  THR_LO_RST  = 16'h0000;
	localparam logic [RESULT_W-1:0]  THR_HI_RST  = 16'hffff;
	localparam logic [PERS_W-1:0]    PERS_RST    = 4'h0;
	localparam logic [STATUS_W-1:0]  MASK_RST    = 2'h0;

	// Sequencer states
	typedef enum logic [1:0] {
		FSM_SLEEP = 2'b00,
		FSM_IDLE  = 2'b01,
		FSM_INTEG = 2'b10,
		FSM_WAIT  = 2'b11
	} lsti_state_t;

	// Setting counts down from the top: all ones gives one step
	function automatic logic [STEPS_W-1:0] lsti_steps(
		input logic [SETTING_W-1:0] setting
	);
		return STEP_SPAN - {1'b0, setting};
	endfunction

	// Saturating add of one clamped step sample to a result
	function automatic logic [RESULT_W-1:0] lsti_sat_add(
		input logic [RESULT_W-1:0] acc,
		input logic [SAMPLE_W-1:0] sample
	);
		logic [SAMPLE_W-1:0] clamped;
		logic [RESULT_W:0]   sum;
		clamped = (sample > SAMPLE_MAX) ? SAMPLE_MAX : sample;
		sum = {1'b0, acc} + {6'h00, clamped};
		return sum[RESULT_W] ? RESULT_MAX : sum[RESULT_W-1:0];
	endfunction

endpackage

// ### shared/lsti_seq_if.sv
// Sequencer link between the control core, the step timer and the converter
`timescale 1ns/1ns
interface lsti_seq_if;
	import lsti_pkg::*;

	logic                start;     // Load a new step count
	logic                abort;     // Stop the running interval
	logic                integrate; // With start: interval integrates
	logic [STEPS_W-1:0]  steps;     // With start: number of steps
	logic                step;      // One step elapsed
	logic                done;      // Last step of the interval
	logic [RESULT_W-1:0] fs_result; // Full spectrum result
	logic [RESULT_W-1:0] ir_result; // Infrared result
	logic                valid;     // Results ready, one cycle

	// Control core
	modport ctl (output start, abort, integrate, steps,
		input fs_result, ir_result, valid);
	// Step timer
	modport tmr (input start, abort, steps, output step, done);
	// Converter
	modport cnv (input start, abort, integrate, step, done,
		output fs_result, ir_result, valid);
endinterface
